// *** rtl/rac_alarm_ctrl.v ***
// Purpose: Alarm control of a real-time clock, Avalon-MM slave
// Assumes: Field match inputs come from core_clk logic
// Notes:   resetn is the power-on reset; sys_reset_n is the rest
//
// Summary of operation
// [RULE1] Enable bit 15 turns alarms on/off
// [RULE2] Wrap set: repeat count rolls 00 to FF
// [RULE3] Wrap clear: repeat count halts at 00
// [RULE4] Disabled: bit 13 sets pulse start level
// [RULE5] Enabled: bit 13 read-only, shows pulse
// [RULE6] Bit 12 flags a read near rollover
// [RULE7] Bit 12 zero only beyond 32 cycles
// [RULE8] Software rereads count until two agree
// [RULE9] Safe read needs reads under 32 cycles
// [RULE10] Bits 11-8 pick half-second to ten-minute period
// [RULE11] Codes 5 to 9: hour to year
// [RULE12] Yearly on February 29: every four years
// [RULE13] Software never uses reserved interval codes
// [RULE14] Event at count 00, no wrap: disable
// [RULE15] Software avoids writes while flag is set
// [RULE16] Only power-on reset clears the control
// [RULE17] Bits 31-16 read as zero
// [RULE18] Each event decrements the repeat count, except at 00 with wrap clear
// [RULE19] Each enabled event toggles the pulse
`include "rac_map.vh"

module rac_alarm_ctrl #(
    parameter HALF_SEC_CYC = `RAC_HALF_SEC_CYC,
    parameter PRE_W        = 25,
    parameter RPT_W        = 8
) (
    input  wire                   core_clk,
    input  wire                   resetn,
    input  wire                   sys_reset_n,
    input  wire [3:0]             avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    input  wire [`RAC_NMATCH-1:0] field_match,
    input  wire                   alarm_is_feb29,
    input  wire                   year_is_leap,
    output wire                   half_sec_tick,
    output reg                    alarm_event_r,
    output reg                    alarm_pulse_r,
    output wire                   irq
);

    // ************************************************************
    // Interval decoding
    // ************************************************************
    function [`RAC_NMATCH-1:0] intv_mask;
        input [3:0] code;
        begin
            intv_mask = {`RAC_NMATCH{1'b0}};
            case (code)
                `RAC_INTV_HALF:  intv_mask = 9'h000;  // [RULE10]
                `RAC_INTV_SEC:   intv_mask = 9'h001;
                `RAC_INTV_10SEC: intv_mask = 9'h003;
                `RAC_INTV_MIN:   intv_mask = 9'h007;
                `RAC_INTV_10MIN: intv_mask = 9'h00f;
                `RAC_INTV_HOUR:  intv_mask = 9'h01f;  // [RULE11]
                `RAC_INTV_DAY:   intv_mask = 9'h03f;
                `RAC_INTV_WEEK:  intv_mask = 9'h07f;
                `RAC_INTV_MONTH: intv_mask = 9'h0bf;
                `RAC_INTV_YEAR:  intv_mask = 9'h1bf;
                default:         intv_mask = 9'h1ff;
            endcase
        end
    endfunction

    function intv_legal;
        input [3:0] code;
        begin
            intv_legal = (code <= `RAC_INTV_YEAR);
        end
    endfunction

    // ************************************************************
    // Control state
    // ************************************************************
    reg                 enable_r;
    reg                 wrap_r;
    reg  [3:0]          intv_r;
    reg                 ack_r;
    reg  [`RAC_IRQ_BITS-1:0] stat_r;
    reg  [`RAC_IRQ_BITS-1:0] irq_en_r;
    wire [`RAC_IRQ_BITS-1:0] stat_nxt;
    wire [`RAC_IRQ_BITS-1:0] irq_src;
    wire [RPT_W-1:0]    rpt_count;
    wire                rpt_zero;
    wire                near_roll;
    wire                match_ok;
    wire                leap_ok;
    wire                evt;
    wire                auto_off;
    wire                req;
    wire                wr_go;
    wire                wr_ctrl;
    wire                wr_hi;
    wire                wr_lo;
    wire                wr_en;
    wire                wr_clr;
    wire [31:0]         ctrl_word;

    // ************************************************************
    // Time base and repeat counter
    // ************************************************************
    rac_prescaler #(
        .HALF_SEC_CYC (HALF_SEC_CYC),
        .CNT_W        (PRE_W),
        .SYNC_WIN     (`RAC_SYNC_WIN_CYC)
    ) u_pre (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .half_tick_r  (half_sec_tick),
        .near_roll_r  (near_roll)
    );

    rac_repeat_ctr #(
        .W            (RPT_W)
    ) u_rpt (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .load         (wr_lo),
        .load_val     (avs_writedata[RPT_W-1:0]),
        .step         (evt),
        .wrap         (wrap_r),
        .count_r      (rpt_count),
        .at_zero      (rpt_zero)
    );

    // ************************************************************
    // Alarm event
    // ************************************************************
    assign match_ok = &(field_match | ~intv_mask(intv_r));

    // Feb 29 alarm date only matches in leap years
    assign leap_ok = (intv_r != `RAC_INTV_YEAR) || !alarm_is_feb29
                   || year_is_leap;  // [RULE12]

    // Reserved codes never fire rather than pick a random period
    assign evt = half_sec_tick && enable_r && match_ok
               && leap_ok && intv_legal(intv_r);  // [RULE1]

    assign auto_off = evt && rpt_zero && !wrap_r;  // [RULE14]

    // ************************************************************
    // Bus decode
    // ************************************************************
    // One wait cycle so read data come from a register
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wr_go   = avs_write && ack_r;
    assign wr_ctrl = wr_go && (avs_address == `RAC_OFF_CTRL);
    assign wr_hi   = wr_ctrl && avs_byteenable[1];
    assign wr_lo   = wr_ctrl && avs_byteenable[0];
    assign wr_en   = wr_go && (avs_address == `RAC_OFF_IRQ_EN)
                   && avs_byteenable[0];
    assign wr_clr  = wr_go && (avs_address == `RAC_OFF_IRQ_CLR)
                   && avs_byteenable[0];

    assign ctrl_word = {16'h0000,  // [RULE17]
                        enable_r,
                        wrap_r,
                        alarm_pulse_r,  // [RULE5]
                        near_roll,  // [RULE6]
                        intv_r,
                        rpt_count};

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else if (!sys_reset_n)
        begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req && !ack_r;
            if (avs_read && !ack_r)
            begin
                case (avs_address)
                    `RAC_OFF_CTRL:
                        avs_readdata <= ctrl_word;
                    `RAC_OFF_IRQ_STAT:
                        avs_readdata <= {{(32-`RAC_IRQ_BITS){1'b0}},
                                         stat_r};
                    `RAC_OFF_IRQ_EN:
                        avs_readdata <= {{(32-`RAC_IRQ_BITS){1'b0}},
                                         irq_en_r};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Alarm control register
    // ************************************************************
    // Only the power-on reset touches these fields
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)  // [RULE16]
        begin
            enable_r <= `RAC_RST_ENABLE;
            wrap_r   <= `RAC_RST_WRAP;
            intv_r   <= `RAC_RST_INTV;
        end
        else
        begin
            if (auto_off)
                enable_r <= 1'b0;  // [RULE14]
            else if (wr_hi)
                enable_r <= avs_writedata[`RAC_BIT_ENABLE];  // [RULE1]
            if (wr_hi)
            begin
                wrap_r <= avs_writedata[`RAC_BIT_WRAP];
                intv_r <= avs_writedata[`RAC_INTV_HI:`RAC_INTV_LO];
            end
        end
    end

    // ************************************************************
    // Alarm pulse
    // ************************************************************
    // Write and event are exclusive: one needs enable low, one high
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            alarm_pulse_r <= `RAC_RST_PIV;
        else if (wr_hi && !enable_r)
            alarm_pulse_r <= avs_writedata[`RAC_BIT_PIV];  // [RULE4]
        else if (evt)
            alarm_pulse_r <= ~alarm_pulse_r;  // [RULE19]
    end

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            alarm_event_r <= 1'b0;
        else if (!sys_reset_n)
            alarm_event_r <= 1'b0;
        else
            alarm_event_r <= evt;
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_src[`RAC_IRQ_EVENT] = evt;
    assign irq_src[`RAC_IRQ_DONE]  = auto_off;

    // New event wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `RAC_IRQ_BITS; gi = gi + 1)
        begin : g_stat
            assign stat_nxt[gi] = irq_src[gi]
                || (stat_r[gi] && !(wr_clr && avs_writedata[gi]));
        end
    endgenerate

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stat_r   <= {`RAC_IRQ_BITS{1'b0}};
            irq_en_r <= {`RAC_IRQ_BITS{1'b0}};
        end
        else if (!sys_reset_n)
        begin
            stat_r   <= {`RAC_IRQ_BITS{1'b0}};
            irq_en_r <= {`RAC_IRQ_BITS{1'b0}};
        end
        else
        begin
            stat_r <= stat_nxt;
            if (wr_en)
                irq_en_r <= avs_writedata[`RAC_IRQ_BITS-1:0];
        end
    end

    assign irq = |(stat_r & irq_en_r);

endmodule // rac_alarm_ctrl

// *** rtl/rac_map.vh ***
// Purpose: Register map and timing constants of the alarm control block
// Assumes: 40 MHz core clock
// Notes:   Definitions only
`ifndef RAC_MAP_VH
`define RAC_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RAC_OFF_CTRL      4'h0
`define RAC_OFF_IRQ_STAT  4'h4
`define RAC_OFF_IRQ_EN    4'h8
`define RAC_OFF_IRQ_CLR   4'hc

// ****************************************************************
// Alarm control fields
// ****************************************************************
`define RAC_BIT_ENABLE    15
`define RAC_BIT_WRAP      14
`define RAC_BIT_PIV       13
`define RAC_BIT_UNSAFE    12
`define RAC_INTV_HI       11
`define RAC_INTV_LO       8
`define RAC_RPT_HI        7
`define RAC_RPT_LO        0
`define RAC_RST_ENABLE    1'b0
`define RAC_RST_WRAP      1'b0
`define RAC_RST_PIV       1'b0
`define RAC_RST_INTV      4'h0
`define RAC_RST_RPT       8'h00

// ****************************************************************
// Interval codes
// ****************************************************************
`define RAC_INTV_HALF     4'h0
`define RAC_INTV_SEC      4'h1
`define RAC_INTV_10SEC    4'h2
`define RAC_INTV_MIN      4'h3
`define RAC_INTV_10MIN    4'h4
`define RAC_INTV_HOUR     4'h5
`define RAC_INTV_DAY      4'h6
`define RAC_INTV_WEEK     4'h7
`define RAC_INTV_MONTH    4'h8
`define RAC_INTV_YEAR     4'h9

// ****************************************************************
// Field match inputs
// ****************************************************************
`define RAC_M_HALF        0
`define RAC_M_SEC1        1
`define RAC_M_SEC10       2
`define RAC_M_MIN1        3
`define RAC_M_MIN10       4
`define RAC_M_HOUR        5
`define RAC_M_WDAY        6
`define RAC_M_DAY         7
`define RAC_M_MONTH       8
`define RAC_NMATCH        9

// ****************************************************************
// Interrupts and timing
// ****************************************************************
`define RAC_IRQ_BITS      2
`define RAC_IRQ_EVENT     0
`define RAC_IRQ_DONE      1
`define RAC_CLK_HZ        40000000
`define RAC_HALF_SEC_MS   500
`define RAC_HALF_SEC_CYC  (`RAC_CLK_HZ / 1000 * `RAC_HALF_SEC_MS)
`define RAC_SYNC_WIN_CYC  32

`endif

// *** rtl/rac_prescaler.v ***
// Purpose: Half-second prescaler with rollover-near flag
// Assumes: Single core clock
// Notes:   Flag high while fewer than SYNC_WIN cycles remain
`include "rac_map.vh"

module rac_prescaler #(
    parameter HALF_SEC_CYC = `RAC_HALF_SEC_CYC,
    parameter CNT_W        = 25,
    parameter SYNC_WIN     = `RAC_SYNC_WIN_CYC
) (
    input  wire             core_clk,
    input  wire             resetn,
    output reg              half_tick_r,
    output reg              near_roll_r
);
    localparam [31:0] RELOAD32 = HALF_SEC_CYC - 1;
    localparam [31:0] WIN32    = SYNC_WIN;

    reg  [CNT_W-1:0] cnt_r;
    wire [CNT_W-1:0] cnt_nxt;

    assign cnt_nxt = (cnt_r == {CNT_W{1'b0}}) ? RELOAD32[CNT_W-1:0]
                   : cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r       <= RELOAD32[CNT_W-1:0];
            half_tick_r <= 1'b0;
            near_roll_r <= 1'b0;
        end
        else
        begin
            cnt_r       <= cnt_nxt;
            half_tick_r <= (cnt_nxt == {CNT_W{1'b0}});
            near_roll_r <= (cnt_nxt < WIN32[CNT_W-1:0]); // [RULE6] [RULE7]
        end
    end
endmodule // rac_prescaler

// *** rtl/rac_repeat_ctr.v ***
// Purpose: Alarm repeat down-counter
// Assumes: load and step are single-cycle strobes
// Notes:   Load wins over step in the same cycle
`include "rac_map.vh"

module rac_repeat_ctr #(
    parameter W = 8
) (
    input  wire         core_clk,
    input  wire         resetn,
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         step,
    input  wire         wrap,
    output reg  [W-1:0] count_r,
    output wire         at_zero
);
    assign at_zero = (count_r == {W{1'b0}});

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            count_r <= `RAC_RST_RPT;
        else if (load)
            count_r <= load_val;
        else if (step && (!at_zero || wrap))  // [RULE2] [RULE3] [RULE18]
            count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
    end
endmodule // rac_repeat_ctr

// *** test/rac_alarm_ctrl_chk.sv ***
// Purpose: Port checker of the alarm control block
// Assumes: One clock; resetn is the power-on reset
// Notes:   Bound from the bench top file
module rac_alarm_ctrl_chk #(
    parameter HALF_SEC_CYC = 200
) (
    input wire        core_clk,
    input wire        resetn,
    input wire        sys_reset_n,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        half_sec_tick,
    input wire        alarm_event_r,
    input wire        alarm_pulse_r,
    input wire        irq
);
    reg  [31:0] cyc_r;
    reg         seen_r;
    wire        ans;
    wire        ctl;
    assign ans = avs_read && !avs_waitrequest;
    assign ctl = ans && avs_address == 4'h0;
    // Cycles since the last tick; unchecked until one tick seen
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cyc_r  <= 32'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            cyc_r  <= half_sec_tick ? 32'h0 : cyc_r + 32'h1;
            seen_r <= seen_r | half_sec_tick;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_hi_zero;
        ans |-> avs_readdata[31:16] == 16'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper half not zero");
    property p_unsafe;
        seen_r && ctl && avs_readdata[12]
            |-> cyc_r < 8 || cyc_r + 48 > HALF_SEC_CYC;
    endproperty
    a_unsafe: assert property (p_unsafe)
        else $error("unsafe flag far from rollover");
    property p_safe;
        ctl && !avs_readdata[12] |-> not (##[1:26] half_sec_tick);
    endproperty
    a_safe: assert property (p_safe)
        else $error("safe flag too close to rollover");
    property p_period;
        half_sec_tick && seen_r |-> cyc_r == HALF_SEC_CYC - 1;
    endproperty
    a_period: assert property (p_period)
        else $error("tick period wrong");
    property p_ev_tick;
        alarm_event_r |-> $past(half_sec_tick);
    endproperty
    a_ev_tick: assert property (p_ev_tick)
        else $error("event without tick");
    property p_ev_pulse;
        alarm_event_r |-> $changed(alarm_pulse_r);
    endproperty
    a_ev_pulse: assert property (p_ev_pulse)
        else $error("event without pulse toggle");
    property p_pulse_src;
        $changed(alarm_pulse_r)
            |-> alarm_event_r || $past(avs_write && !avs_waitrequest);
    endproperty
    a_pulse_src: assert property (p_pulse_src)
        else $error("pulse moved without cause");
    property p_rd_fast;
        disable iff (!resetn || !sys_reset_n)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_rd_fast: assert property (p_rd_fast)
        else $error("read answer not after one wait");
    c_event: cover property (alarm_event_r);
    c_unsafe: cover property (ctl && avs_readdata[12]);
    c_irq: cover property (irq);
endmodule // rac_alarm_ctrl_chk

// *** test/rac_alarm_ctrl_test.sv ***
// Purpose: Self-checking bench of the alarm control block
// Assumes: Short half-second count for run time
// Notes:   Writes follow a tick or a power-on reset to stay clear of rollover
`include "rac_map.vh"
module rac_alarm_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam HC = 200;
    logic        core_clk;
    logic        resetn;
    logic        sys_reset_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    logic [8:0]  field_match;
    logic        alarm_is_feb29;
    logic        year_is_leap;
    wire         half_sec_tick;
    wire         alarm_event_r;
    wire         alarm_pulse_r;
    wire         irq;
    int          failures;
    int          check_count;
    logic [31:0] q;
    logic        ev;
    logic        p;
    logic [8:0]  tbl [10] = '{9'h000, 9'h001, 9'h003, 9'h007, 9'h00f,
                              9'h01f, 9'h03f, 9'h07f, 9'h0bf, 9'h1bf};
    rac_alarm_ctrl #(.HALF_SEC_CYC(HC)) u_rac_alarm_ctrl (
        .core_clk(core_clk), .resetn(resetn), .sys_reset_n(sys_reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .field_match(field_match),
        .alarm_is_feb29(alarm_is_feb29), .year_is_leap(year_is_leap),
        .half_sec_tick(half_sec_tick), .alarm_event_r(alarm_event_r),
        .alarm_pulse_r(alarm_pulse_r), .irq(irq));
    task close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: %h vs %h", $time, m, got, exp);
        end
    endtask
    // Holds the request until the edge that samples waitrequest low;
    // returns off the edge so register outputs have settled
    task bus(input logic w, input [3:0] a, input [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(negedge core_clk);
    endtask
    task tick(output logic e);
        do @(negedge core_clk); while (half_sec_tick !== 1'b1);
        @(negedge core_clk);
        e = alarm_event_r;
    endtask
    task t_reset_vals;
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q, 32'h0, "ctrl reset");
        bus(1, 4'h2, 32'hffff_ffff);
        bus(0, 4'h2, 0);
        chk(q, 32'h0, "unmapped");
    endtask
    task t_fields;
        bus(1, `RAC_OFF_CTRL, 32'hffff_2305);
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q & 32'hffff_efff, 32'h0000_2305, "ctrl rw");
        chk(alarm_pulse_r, 1, "start level");
    endtask
    task t_oneshot;
        tick(ev);
        bus(1, `RAC_OFF_IRQ_EN, 32'h3);
        bus(1, `RAC_OFF_CTRL, 32'h0000_8002);
        bus(1, `RAC_OFF_CTRL, 32'h0000_a002);
        chk(alarm_pulse_r, 0, "locked level");
        @(posedge core_clk) field_match <= 9'h1ff;
        for (int i = 0; i < 3; i++)
        begin
            p = alarm_pulse_r;
            tick(ev);
            chk(ev, 1, "event");
            chk(alarm_pulse_r, !p, "toggle");
        end
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q & 32'hffff_efff, {18'h0, alarm_pulse_r, 13'h0}, "off");
        tick(ev);
        chk(ev, 0, "disabled");
        bus(0, `RAC_OFF_IRQ_STAT, 0);
        chk(q, 32'h3, "status");
        chk(irq, 1, "irq up");
        bus(1, `RAC_OFF_IRQ_EN, 0);
        chk(irq, 0, "irq masked");
        bus(1, `RAC_OFF_IRQ_CLR, 32'h3);
        bus(1, `RAC_OFF_IRQ_EN, 32'h3);
        chk(irq, 0, "irq cleared");
    endtask
    task t_codes;
        for (int c = 0; c < 10; c++)
        begin
            tick(ev);
            bus(1, `RAC_OFF_CTRL, {16'h0, 4'hc, c[3:0], 8'h00});
            @(posedge core_clk) field_match <= tbl[c] & (tbl[c] - 9'h1);
            tick(ev);
            chk(ev, c == 0, "partial match");
            @(posedge core_clk) field_match <= tbl[c];
            tick(ev);
            chk(ev, 1, "full match");
        end
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q & 32'hffff_cfff, 32'h0000_c9ff, "wrapped");
        @(posedge core_clk) alarm_is_feb29 <= 1'b1;
        tick(ev);
        chk(ev, 0, "not leap");
        @(posedge core_clk) year_is_leap <= 1'b1;
        tick(ev);
        chk(ev, 1, "leap");
    endtask
    task t_unsafe;
        tick(ev);
        repeat (HC - 20) @(negedge core_clk);
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q[12], 1, "near rollover");
        p = q[7:0] == 8'h00;
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q[7:0] == 8'h00, p, "count reread agrees");
        tick(ev);
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q[12], 0, "far from rollover");
    endtask
    task t_sysrst;
        tick(ev);
        bus(1, `RAC_OFF_CTRL, 32'h0000_435a);
        p = alarm_pulse_r;
        @(posedge core_clk) sys_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        sys_reset_n <= 1'b1;
        bus(0, `RAC_OFF_CTRL, 0);
        chk(q & 32'hffff_efff, {18'h1, p, 13'h035a}, "kept");
        chk(alarm_pulse_r, p, "level kept");
        @(posedge core_clk) resetn <= 1'b0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_vals;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Bound far above the ~8000 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end
    initial
    begin
        failures = 0;
        check_count = 0;
        resetn = 1'b0;
        sys_reset_n = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        field_match = 9'h000;
        alarm_is_feb29 = 1'b0;
        year_is_leap = 1'b0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_vals;
        t_fields;
        t_oneshot;
        t_codes;
        t_unsafe;
        t_sysrst;
        close_out;
    end
endmodule // rac_alarm_ctrl_test
bind rac_alarm_ctrl rac_alarm_ctrl_chk #(.HALF_SEC_CYC(HALF_SEC_CYC))
    u_rac_alarm_ctrl_chk (
    .core_clk(core_clk), .resetn(resetn), .sys_reset_n(sys_reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .half_sec_tick(half_sec_tick),
    .alarm_event_r(alarm_event_r), .alarm_pulse_r(alarm_pulse_r),
    .irq(irq));
